/* File: hw/sbd_consts.svh */
// sbd_consts.svh - offsets, field positions, reset values and timing counts
// of the servo burst demodulator control block.
// assumes: included by bare name from the package; the design files use its macros.
`ifndef SBD_CONSTS_SVH
`define SBD_CONSTS_SVH

// ----------------------------------------------------------------------
// register map (word index, byte address is four times the index)
// ----------------------------------------------------------------------
`define SBD_MODE_IDX       4'hb
`define SBD_STAT_IDX       4'hc
`define SBD_MODE_RST       8'h00
`define SBD_MODE_MSB       7
`define SBD_MODE_LSB       5

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define SBD_ST_DET_LSB     0
`define SBD_ST_SEL_LSB     2
`define SBD_ST_SELV_BIT    4
`define SBD_ST_TACT_BIT    5
`define SBD_ST_TMODE_LSB   6
`define SBD_ST_TRACK_LSB   9

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SBD_CLK_PERIOD_NS  50
`define SBD_OS_TIME_NS     500
`define SBD_OS_CYC         ((`SBD_OS_TIME_NS) / (`SBD_CLK_PERIOD_NS))
`define SBD_SYNC_DLY       2
`define SBD_CNT_STEP_SH    2

`endif

/* File: hw/sbd_pkg.sv */
// sbd_pkg.sv - types shared by the servo burst demodulator control files.
// assumes: sbd_consts.svh sits on the include path.
package sbd_pkg;
  `include "sbd_consts.svh"

  // burst capture sequencer states
  typedef enum logic [1:0] {
    BST_IDLE,
    BST_WAIT,
    BST_TRACK,
    BST_HOLD
  } sbd_burst_e;

  typedef logic [1:0] sbd_det_t;   // detector index a..d
  typedef logic [2:0] sbd_mode_t;  // capture or test mode word
endpackage

/* File: hw/sbd_os_if.sv */
// sbd_os_if.sv - trigger and pulse between the control core and the
// automatic reset one-shot.
// assumes: both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sbd_os_if;
  logic trig;   // level: servo gate high and standby asserted
  logic pulse;  // reset pulse out of the one-shot

  modport ctl (output trig, input pulse);
  modport os  (input trig, output pulse);
endinterface
`default_nettype wire

/* File: hw/sbd_reset_oneshot.sv */
// sbd_reset_oneshot.sv - automatic servo reset one-shot.
// assumes: trig is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
module sbd_reset_oneshot
  import sbd_pkg::*;
#(
  parameter int OS_CYC = `SBD_OS_CYC
) (
  input  wire logic clk_i,    // 20 MHz clock
  input  wire logic rst_n_i,  // async reset, active low
  sbd_os_if.os      os        // trigger in, pulse out
);
  logic       trig_q;
  logic [7:0] cnt_q;
  logic       trig_rise;

  assign trig_rise = os.trig & ~trig_q;

  // pulse starts on the rising trigger and lasts OS_CYC cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else begin
      trig_q <= os.trig;
      if (trig_rise) begin
        cnt_q <= 8'(OS_CYC);
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  assign os.pulse = (cnt_q != 8'h00);

  logic [7:0] run_q;

  // helper: length of the running pulse, saturating so retriggers are safe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 8'h00;
    end else begin
      run_q <= !os.pulse ? 8'h00 :
               (run_q == 8'hff) ? run_q : 8'(run_q + 8'h01);
    end
  end

  chk_oneshot_width: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(os.pulse) |-> run_q >= 8'(OS_CYC))
    else $error("one-shot pulse shorter than its width");
endmodule // sbd_reset_oneshot
`default_nettype wire

/* File: hw/sbd_top.sv */
// sbd_top.sv - servo burst demodulator control, test mode entry and peak
// qualification output logic.
// assumes: all pin inputs are asynchronous to clk_i; the analog side
// delivers the zero-cross comparator and slope comparators as logic levels.
//
// Behaviour
// - mode 000: detector tracks from burst gate rise until its fall
// - nonzero mode: burst gate rise synchronised to the servo clock
// - servo clock ticks on each falling zero-cross comparator edge
// - 5-bit counter counts servo clocks; limit from mode bits 7:5
// - mode 000 async, modes 1..7 count four times the mode value
// - burst gate falling early puts the active detector into hold
// - successive bursts go to detectors a, b, c, d in turn
// - each detector select rising edge steps the output a, b, c, d
// - servo reset low clears control, detectors, output to reference
// - servo gate high with standby asserted fires a 500 ns reset
// - on test entry the mode pins are captured and decoded
// - test mode stays until servo reset is sampled low
// - test modes reroute pulse outputs; modes 4..7 float them
// - slope hit outputs follow the slope threshold comparators
// - qualified same-polarity rising peak gives data and erase pulse
// - synced burst gate rises two servo cycles after the burst gate
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sbd_top
  import sbd_pkg::*;
(
  input  wire logic        clk_i,                  // 20 MHz clock
  input  wire logic        rst_n_i,                // async reset, low
  // wishbone classic slave
  input  wire logic        wb_cyc_i,               // bus cycle
  input  wire logic        wb_stb_i,               // strobe
  input  wire logic        wb_we_i,                // write enable
  input  wire logic [7:0]  wb_adr_i,               // byte address
  input  wire logic [3:0]  wb_sel_i,               // byte lanes
  input  wire logic [31:0] wb_dat_i,               // write data
  output logic      [31:0] wb_dat_o,               // read data
  output logic             wb_ack_o,               // acknowledge
  // controller pins
  input  wire logic        burst_gate_i,           // burst capture gate
  input  wire logic        detector_select_step_i, // output select step
  input  wire logic        servo_reset_n_i,        // servo reset, low
  input  wire logic        servo_gate_i,           // servo mode
  input  wire logic        standby_n_i,            // standby, low
  input  wire logic        gain_hold_n_i,          // gain hold, low
  input  wire logic        programmed_gain_mode_i, // gain mode
  input  wire logic [2:0]  mode_pins_i,            // test mode pins
  // analog side comparators
  input  wire logic        zero_cross_i,           // servo zero-cross
  input  wire logic        pos_slope_over_i,       // pos slope > thr
  input  wire logic        neg_slope_over_i,       // neg slope > thr
  input  wire logic        peak_strobe_i,          // peak found level
  input  wire logic        peak_pol_i,             // 1 = positive peak
  input  wire logic        peak_higher_i,          // amplitude rose
  input  wire logic [6:0]  test_obs_i,             // test observables
  // outputs
  output logic [3:0]       track_o,                // detector a..d track
  output logic             burst_gate_synced_o,    // synced burst gate
  output logic [1:0]       detector_sel_o,         // routed detector
  output logic             position_reset_o,       // output to reference
  output logic             pos_slope_hit_o,        // pos slope hit
  output logic             neg_slope_hit_o,        // neg slope hit
  output logic             qualified_pulse_p_o,    // data pulse, true
  output logic             qualified_pulse_n_o,    // data pulse, compl.
  output logic             erase_pulse_p_o,        // erase pulse, true
  output logic             erase_pulse_n_o,        // erase pulse, compl.
  output logic             pulse_drv_oe_o,         // pulse pins driven
  output logic             test_active_o,          // test mode on
  output logic [2:0]       test_mode_o             // captured test mode
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  localparam int NP = 23;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] sync1_q;
  logic [NP-1:0] sync2_q;

  assign pin_raw = {test_obs_i, mode_pins_i, pos_slope_over_i,
                    neg_slope_over_i, peak_strobe_i, peak_pol_i,
                    peak_higher_i, zero_cross_i, gain_hold_n_i,
                    programmed_gain_mode_i, standby_n_i, servo_gate_i,
                    servo_reset_n_i, detector_select_step_i,
                    burst_gate_i};

  // two flops per pin; only the second stage is ever read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  wire       bg_s     = sync2_q[0];
  wire       step_s   = sync2_q[1];
  wire       srst_n_s = sync2_q[2];
  wire       servo_gate_s  = sync2_q[3];
  wire       stby_n_s = sync2_q[4];
  wire       pgm_s    = sync2_q[5];
  wire       hold_n_s = sync2_q[6];
  wire       zc_s     = sync2_q[7];
  wire       phigh_s  = sync2_q[8];
  wire       ppol_s   = sync2_q[9];
  wire       pstb_s   = sync2_q[10];
  wire       nover_s  = sync2_q[11];
  wire       pover_s  = sync2_q[12];
  wire [2:0] mpin_s   = sync2_q[15:13];
  wire [6:0] obs_s    = sync2_q[22:16];

  // ----------------------------------------------------------------------
  // edge detection and servo reset
  // ----------------------------------------------------------------------
  logic bg_q, step_q, zc_q, pstb_q;
  sbd_os_if os_bus ();

  // servo clock tick is a one-cycle enable on the falling zero crossing
  wire zc_tick   = zc_q & ~zc_s;
  wire bg_rise   = bg_s & ~bg_q;
  wire step_rise = step_s & ~step_q;
  wire pk_evt    = pstb_s & ~pstb_q;
  wire srst      = ~srst_n_s | os_bus.pulse;

  assign os_bus.trig = servo_gate_s & ~stby_n_s;

  sbd_reset_oneshot #(
    .OS_CYC (`SBD_OS_CYC)
  ) u_oneshot (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .os      (os_bus)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bg_q   <= 1'b0;
      step_q <= 1'b0;
      zc_q   <= 1'b0;
      pstb_q <= 1'b0;
    end else begin
      bg_q   <= bg_s;
      step_q <= step_s;
      zc_q   <= zc_s;
      pstb_q <= pstb_s;
    end
  end

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [7:0] mode_reg_q;
  logic       ack_q;
  logic [31:0] rdat_q;
  wire        req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire [3:0]  idx      = wb_adr_i[5:2];
  wire        in_range = (wb_adr_i[7:6] == 2'b00);
  wire        hit_mode = in_range & (idx == `SBD_MODE_IDX);
  wire        hit_stat = in_range & (idx == `SBD_STAT_IDX);
  wire        mode_wr  = req & wb_we_i & hit_mode & wb_sel_i[0];
  wire sbd_mode_t cap_mode = mode_reg_q[`SBD_MODE_MSB:`SBD_MODE_LSB];
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  // unmapped addresses still answer, reading zero and ignoring writes
  assign rd_mux = hit_mode ? {24'h000000, mode_reg_q} :
                  hit_stat ? stat_word : 32'h00000000;

  // single-cycle answer; ack drops the cycle after it was given
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q      <= 1'b0;
      rdat_q     <= 32'h00000000;
      mode_reg_q <= `SBD_MODE_RST;
    end else begin
      ack_q <= req;
      if (req) begin
        rdat_q <= rd_mux;
      end
      if (mode_wr) begin
        mode_reg_q <= wb_dat_i[7:0];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------------
  // burst capture sequencer
  // ----------------------------------------------------------------------
  sbd_burst_e st_q, st_d;
  sbd_det_t   det_q, det_d;
  logic [1:0] dly_q, dly_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] track_q;
  logic       synced_q;
  wire        async_md = (cap_mode == 3'b000);
  wire [4:0]  cnt_lim  = {2'b00, cap_mode} << `SBD_CNT_STEP_SH;
  wire [4:0]  cnt_inc  = 5'(cnt_q + 5'h01);
  wire        lim_hit  = zc_tick & (cnt_inc == cnt_lim);

  // next state; early gate fall always wins over the cycle count
  always_comb begin
    st_d  = st_q;
    det_d = det_q;
    dly_d = dly_q;
    cnt_d = cnt_q;
    case (st_q)
      BST_IDLE: begin
        dly_d = 2'b00;
        cnt_d = 5'h00;
        if (bg_rise) begin
          st_d = async_md ? BST_TRACK : BST_WAIT;
        end
      end
      BST_WAIT: begin
        if (!bg_s) begin
          st_d  = BST_IDLE;
          det_d = sbd_det_t'(det_q + 2'b01);
        end else if (zc_tick) begin
          dly_d = 2'(dly_q + 2'b01);
          if (dly_q == 2'(`SBD_SYNC_DLY - 1)) begin
            st_d = BST_TRACK;
          end
        end
      end
      BST_TRACK: begin
        if (!bg_s) begin
          st_d  = BST_IDLE;
          det_d = sbd_det_t'(det_q + 2'b01);
          cnt_d = 5'h00;
        end else if (!async_md && lim_hit) begin
          st_d  = BST_HOLD;
          det_d = sbd_det_t'(det_q + 2'b01);
          cnt_d = 5'h00;
        end else if (!async_md && zc_tick) begin
          cnt_d = cnt_inc;
        end
      end
      BST_HOLD: begin
        if (!bg_s) begin
          st_d = BST_IDLE;
        end
      end
      default: begin
        st_d = BST_IDLE;
      end
    endcase
  end

  // sequencer registers; servo reset clears everything synchronously
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q     <= BST_IDLE;
      det_q    <= 2'b00;
      dly_q    <= 2'b00;
      cnt_q    <= 5'h00;
      synced_q <= 1'b0;
    end else if (srst) begin
      st_q     <= BST_IDLE;
      det_q    <= 2'b00;
      dly_q    <= 2'b00;
      cnt_q    <= 5'h00;
      synced_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      det_q    <= det_d;
      dly_q    <= dly_d;
      cnt_q    <= cnt_d;
      synced_q <= (st_d == BST_TRACK) & ~async_md;
    end
  end

  // one track enable per detector, only the active one may track
  for (genvar g = 0; g < 4; g++) begin : g_track
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        track_q[g] <= 1'b0;
      end else begin
        track_q[g] <= ~srst & (st_d == BST_TRACK) &
                      (det_q == sbd_det_t'(g));
      end
    end
  end

  assign track_o             = track_q;
  assign burst_gate_synced_o = synced_q;

  // ----------------------------------------------------------------------
  // detector output select
  // ----------------------------------------------------------------------
  logic [1:0] sel_q;
  logic       sel_v_q;
  logic       pos_rst_q;

  // first step after reset picks a, later steps walk and wrap
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_q     <= 2'b00;
      sel_v_q   <= 1'b0;
      pos_rst_q <= 1'b1;
    end else begin
      pos_rst_q <= srst;
      if (srst) begin
        sel_q   <= 2'b00;
        sel_v_q <= 1'b0;
      end else if (step_rise) begin
        sel_v_q <= 1'b1;
        sel_q   <= sel_v_q ? 2'(sel_q + 2'b01) : 2'b00;
      end
    end
  end

  assign detector_sel_o   = sel_q;
  assign position_reset_o = pos_rst_q;

  // ----------------------------------------------------------------------
  // peak qualification and slope hits
  // ----------------------------------------------------------------------
  logic last_v_q, last_pol_q, qual_q, pos_hit_q, neg_hit_q;
  wire  qual_d = pk_evt & last_v_q & (ppol_s == last_pol_q) & phigh_s;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_v_q   <= 1'b0;
      last_pol_q <= 1'b0;
      qual_q     <= 1'b0;
      pos_hit_q  <= 1'b0;
      neg_hit_q  <= 1'b0;
    end else begin
      pos_hit_q <= pover_s;
      neg_hit_q <= nover_s;
      qual_q    <= qual_d;
      if (pk_evt) begin
        last_v_q   <= 1'b1;
        last_pol_q <= ppol_s;
      end
    end
  end

  assign pos_slope_hit_o = pos_hit_q;
  assign neg_slope_hit_o = neg_hit_q;

  // ----------------------------------------------------------------------
  // test mode entry, exit and output routing
  // ----------------------------------------------------------------------
  logic       tact_q;
  logic [2:0] tmode_q;
  logic [3:0] pin_q;
  logic       oe_q;
  logic [3:0] pin_d;
  wire        t_entry = ~hold_n_s & pgm_s & srst_n_s;

  // test routing order per mode: {erase n, erase p, data n, data p}
  assign pin_d = !tact_q ? {~qual_q, qual_q, ~qual_q, qual_q} :
                 (tmode_q == 3'd0) ? obs_s[3:0] :
                 (tmode_q == 3'd1) ? {obs_s[4], last_v_q,
                                      neg_hit_q, pos_hit_q} :
                 (tmode_q == 3'd2) ? {obs_s[6], obs_s[5], bg_s, step_s} :
                 (tmode_q == 3'd3) ? {os_bus.pulse, ~synced_q,
                                      synced_q, zc_s} : 4'h0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tact_q  <= 1'b0;
      tmode_q <= 3'b000;
      pin_q   <= 4'h0;
      oe_q    <= 1'b1;
    end else begin
      if (!srst_n_s) begin
        tact_q <= 1'b0;
      end else if (t_entry && !tact_q) begin
        tact_q  <= 1'b1;
        tmode_q <= mpin_s;
      end
      pin_q <= pin_d;
      oe_q  <= ~(tact_q & tmode_q[2]);
    end
  end

  assign qualified_pulse_p_o = pin_q[0];
  assign qualified_pulse_n_o = pin_q[1];
  assign erase_pulse_p_o     = pin_q[2];
  assign erase_pulse_n_o     = pin_q[3];
  assign pulse_drv_oe_o      = oe_q;
  assign test_active_o       = tact_q;
  assign test_mode_o         = tmode_q;

  assign stat_word = {19'h00000, track_q, tmode_q, tact_q, sel_v_q,
                      sel_q, det_q};

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_track_single: assert property ($onehot0(track_o))
    else $error("more than one detector tracking");
  chk_async_stop: assert property (
    async_md && !srst && track_o != 4'h0 && !bg_s |=> track_o == 4'h0)
    else $error("async capture not stopped at gate fall");
  chk_fail_safe: assert property (
    synced_q && !bg_s |=> !synced_q && track_o == 4'h0)
    else $error("early gate fall did not hold detector");
  chk_sync_rise: assert property (
    st_q == BST_WAIT && zc_tick && dly_q == 2'b01 && bg_s && !srst
    |=> synced_q)
    else $error("synced gate not raised after two servo cycles");
  chk_count_end: assert property (
    synced_q && bg_s && lim_hit && !srst |=> !synced_q ##1 !synced_q)
    else $error("sampling not ended at programmed count");
  chk_cnt_clear: assert property (!synced_q |-> cnt_q == 5'h00)
    else $error("cycle counter not cleared");
  chk_det_wrap: assert property (
    st_q == BST_TRACK && st_d != BST_TRACK && !srst
    |=> det_q == sbd_det_t'($past(det_q) + 2'b01))
    else $error("detector assignment did not advance");
  chk_reset_ref: assert property (
    srst |=> position_reset_o && track_o == 4'h0 && !sel_v_q)
    else $error("servo reset did not clear demodulator");
  chk_select_step: assert property (
    step_rise && !srst && sel_v_q
    |=> detector_sel_o == 2'($past(sel_q) + 2'b01))
    else $error("select step did not advance output");
  chk_test_hold: assert property (
    tact_q && srst_n_s |=> tact_q && $stable(tmode_q))
    else $error("test mode left without servo reset");
  chk_test_float: assert property (
    tact_q && tmode_q[2] |=> !pulse_drv_oe_o)
    else $error("pulse pins driven in floating test mode");
  chk_qual_pair: assert property (
    !tact_q |=> qualified_pulse_p_o == erase_pulse_p_o)
    else $error("data and erase pulses not coincident");

  cov_async_burst: cover property (async_md && $fell(track_o[0]));
  cov_sync_full:   cover property (synced_q && lim_hit);
  cov_wrap_d:      cover property (det_q == 2'b11 ##1 det_q == 2'b00);
  cov_test_entry:  cover property ($rose(tact_q));
endmodule // sbd_top
`default_nettype wire

/* File: verification/sbd_servo_model.sv */
// sbd_servo_model.sv - far side model: servo waveform zero-cross source.
// assumes: clk_i is the bench clock; the waveform runs free like a disk.
`timescale 1ns/1ps
`default_nettype none
module sbd_servo_model #(
  parameter int HALF = 4
) (
  input  wire logic clk_i,        // bench clock
  output logic      zero_cross_o  // comparator level
);
  int cnt = 0;
  // ------------------------------------------------------------
  // waveform
  // ------------------------------------------------------------
  // square wave, each falling edge is one servo tick
  initial zero_cross_o = 1'b1;
  always @(posedge clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) zero_cross_o <= ~zero_cross_o;
  end
endmodule // sbd_servo_model
`default_nettype wire

/* File: verification/sbd_top_test.sv */
// sbd_top_test.sv - self-checking bench for the demodulator control block.
// assumes: sbd_pkg and sbd_servo_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sbd_top_test import sbd_pkg::*;;
  logic clk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic burst_gate_i = 0, detector_select_step_i = 0, servo_reset_n_i = 1;
  logic servo_gate_i = 0, standby_n_i = 1, gain_hold_n_i = 1;
  logic programmed_gain_mode_i = 0, zero_cross_i, pos_slope_over_i = 0;
  logic [2:0] mode_pins_i = 0, test_mode_o;
  logic [3:0] track_o;
  logic [1:0] detector_sel_o;
  logic burst_gate_synced_o, position_reset_o, pos_slope_hit_o;
  logic neg_slope_hit_o, pulse_drv_oe_o, test_active_o;
  logic peak_strobe_i = 0, peak_pol_i = 0, peak_higher_i = 0;
  logic qualified_pulse_p_o, qualified_pulse_n_o;
  logic erase_pulse_p_o, erase_pulse_n_o;
  int err_count = 0, n_tests = 0, hi, n_qual = 0;
  typedef struct {logic [7:0] a; logic [31:0] d, e;} sbd_row_s;
  sbd_row_s rows[5] = '{'{8'h2c, 32'h1234_56e5, 32'he5},
    '{8'h04, 32'hff, 32'h0}, '{8'hac, 32'hff, 32'h0},
    '{8'h30, 32'hff, 32'h0}, '{8'h2c, 0, 0}};

  sbd_servo_model #(.HALF(4)) MODEL (.clk_i, .zero_cross_o(zero_cross_i));
  sbd_top DUT (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .burst_gate_i, .detector_select_step_i, .servo_reset_n_i, .servo_gate_i,
    .standby_n_i, .gain_hold_n_i, .programmed_gain_mode_i, .mode_pins_i,
    .zero_cross_i, .pos_slope_over_i, .neg_slope_over_i(pos_slope_over_i),
    .peak_strobe_i, .peak_pol_i, .peak_higher_i,
    .test_obs_i(7'h0), .track_o, .burst_gate_synced_o, .detector_sel_o,
    .position_reset_o, .pos_slope_hit_o, .neg_slope_hit_o,
    .qualified_pulse_p_o, .qualified_pulse_n_o, .erase_pulse_p_o,
    .erase_pulse_n_o, .pulse_drv_oe_o, .test_active_o, .test_mode_o);

  always #25 clk_i = ~clk_i;
  // the data pulse stands one cycle, so it is counted where it stands
  always @(negedge clk_i)
    if ({qualified_pulse_p_o, qualified_pulse_n_o, erase_pulse_p_o,
         erase_pulse_n_o} === 4'b1010) n_qual++;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tout;
    err_count++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask
  // ack is looked at on the edge itself, so read data is what that edge saw
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, d};
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (wb_ack_o !== 1'b1) tout();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
  endtask
  task automatic await(input int id, input logic v);
    logic s;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_i);
      s = id == 0 ? track_o != 0 : id == 1 ? burst_gate_synced_o :
          id == 2 ? position_reset_o : test_active_o;
      if (s === v) return;
    end
    tout();
  endtask
  task automatic step;
    @(posedge clk_i) detector_select_step_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    detector_select_step_i <= 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic pk(input logic pol, h);
    @(posedge clk_i);
    {peak_strobe_i, peak_pol_i, peak_higher_i} <= {1'b1, pol, h};
    repeat (4) @(posedge clk_i);
    peak_strobe_i <= 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_i);
    chk({position_reset_o, track_o, pulse_drv_oe_o}, 6'h21);
    @(posedge clk_i) rst_n_i <= 1'b1;
    await(2, 0);
    foreach (rows[i]) begin
      wb(1, rows[i].a, rows[i].d);
      wb(0, rows[i].a, 0);
      chk(rd, rows[i].e);
    end
    @(posedge clk_i) burst_gate_i <= 1'b1;
    await(0, 1);
    chk(track_o, 4'h1);
    @(posedge clk_i) burst_gate_i <= 1'b0;
    await(0, 0);
    wb(1, 8'h2c, 32'h20);
    @(posedge clk_i) burst_gate_i <= 1'b1;
    await(1, 1);
    chk(track_o, 4'h2);
    for (hi = 0; burst_gate_synced_o === 1'b1 && hi < 400; hi++)
      @(negedge clk_i);
    chk(hi >= 28 && hi <= 36, 1);
    @(posedge clk_i) burst_gate_i <= 1'b0;
    wb(1, 8'h2c, 32'he0);
    @(posedge clk_i) burst_gate_i <= 1'b1;
    await(1, 1);
    @(posedge clk_i) burst_gate_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk(track_o, 4'h0);
    @(posedge clk_i) burst_gate_i <= 1'b1;
    await(1, 1);
    chk(track_o, 4'h8);
    @(posedge clk_i) burst_gate_i <= 1'b0;
    await(0, 0);
    wb(0, 8'h30, 0);
    chk(rd[1:0], 2'h0);
    step();
    chk(detector_sel_o, 2'h0);
    step();
    chk(detector_sel_o, 2'h1);
    @(posedge clk_i) pos_slope_over_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk({pos_slope_hit_o, neg_slope_hit_o}, 2'h3);
    pk(1, 1);
    pk(1, 1);
    pk(1, 0);
    pk(0, 1);
    chk(n_qual, 1);
    @(posedge clk_i) {gain_hold_n_i, programmed_gain_mode_i} <= 2'b01;
    mode_pins_i <= 3'h5;
    await(3, 1);
    @(negedge clk_i); // routing follows one cycle after entry
    chk({test_mode_o, pulse_drv_oe_o}, 4'ha);
    @(posedge clk_i) servo_reset_n_i <= 1'b0;
    await(3, 0);
    chk(position_reset_o, 1);
    @(posedge clk_i) {servo_reset_n_i, gain_hold_n_i} <= 2'b11;
    await(2, 0);
    @(posedge clk_i) {servo_gate_i, standby_n_i} <= 2'b10;
    await(2, 1);
    for (hi = 0; position_reset_o === 1'b1 && hi < 400; hi++)
      @(negedge clk_i);
    chk(hi, 10);
    complete_run();
  end
endmodule // sbd_top_test
`default_nettype wire
